/* File: oes_cfg.svh */
// Purpose: Register offsets, field positions and counts of the output stop unit
// Assumes: 16-bit register data, 3-bit register index
// Notes:   Definitions only
`ifndef OES_CFG_SVH
`define OES_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OES_ADDR_W          3
`define OES_DATA_W          16
`define OES_OFS_FAULT_A     3'h0
`define OES_OFS_FAULT_B     3'h1
`define OES_OFS_FAULT_C     3'h2
`define OES_OFS_OSC         3'h3
`define OES_OFS_OVL_ONE     3'h4
`define OES_OFS_OVL_TWO     3'h5
`define OES_OFS_IRQ_STAT    3'h6
`define OES_OFS_IRQ_MASK    3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OES_MODE_MSB        3
`define OES_MODE_LSB        0
`define OES_BASIC_MODE_MSB  1
`define OES_CNT_MSB         7
`define OES_CNT_LSB         4
`define OES_EN_BIT          9
`define OES_FLAG_BIT        15
`define OES_EVT_W           6
`define OES_NUM_FAULT       3

// ----------------------------------------------------------------
// Sampling
// ----------------------------------------------------------------
`define OES_PRESC_W         7
`define OES_RUN_W           5
`define OES_CNT_SEL_4       4'h0
`define OES_CNT_SEL_8       4'h1
`define OES_RUN_4           5'h04
`define OES_RUN_8           5'h08
`define OES_RUN_16          5'h10
`define OES_PRESC_STEP      7'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OES_PIN_OUT_RST     4'h0
`define OES_PIN_OE_RST      4'h0
`define OES_PIN_STOP_LVL    4'h0
`define OES_PIN_ALL_ON      4'hF

`endif

/* File: oes_pkg.sv */
// Purpose: Types and shared decoding of the output stop unit
// Assumes: oes_cfg.svh on the include path
// Notes:   Basic 2-bit mode codes coincide with the low extended codes
`include "oes_cfg.svh"

package oes_pkg;

    typedef enum logic [3:0]
    {
        OES_EDGE   = 4'h0,
        OES_DIV8   = 4'h1,
        OES_DIV16  = 4'h2,
        OES_DIV128 = 4'h3,
        OES_DIV1   = 4'h4,
        OES_DIV2   = 4'h5,
        OES_DIV4   = 4'h6
    } oes_mode_type;

    // Sample strobe of the selected divided clock
    function automatic logic oes_tick(input logic [3:0] mode,
                                      input logic [`OES_PRESC_W-1:0] presc);
        logic t;
        t = 1'b0;
        case (mode)
            OES_DIV1:   t = 1'b1;
            OES_DIV2:   t = presc[0];
            OES_DIV4:   t = &presc[1:0];
            OES_DIV8:   t = &presc[2:0];
            OES_DIV16:  t = &presc[3:0];
            OES_DIV128: t = &presc;
            default:    t = 1'b0;
        endcase
        return t;
    endfunction : oes_tick

    // Consecutive low samples needed for acceptance
    function automatic logic [`OES_RUN_W-1:0] oes_target(input logic extended,
                                                          input logic [3:0] cnt);
        logic [`OES_RUN_W-1:0] r;
        r = `OES_RUN_16;
        if (extended)
        begin
            case (cnt)
                `OES_CNT_SEL_4: r = `OES_RUN_4;
                `OES_CNT_SEL_8: r = `OES_RUN_8;
                default:        r = `OES_RUN_16;
            endcase
        end
        return r;
    endfunction : oes_target

endpackage : oes_pkg

/* File: oes_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Input asynchronous to mclk
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/1ps

module oes_sync
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic pin_raw,
    input  wire logic rst_level,
    output logic      pin_clean
);

    typedef struct packed
    {
        logic ff1;
        logic ff2;
        logic ff3;
        logic out;
    } oes_sync_state_type;

    oes_sync_state_type s;
    oes_sync_state_type next_s;

    always_comb
    begin
        next_s     = s;
        next_s.ff1 = pin_raw;
        next_s.ff2 = s.ff1;
        next_s.ff3 = s.ff2;
        if (s.ff2 == s.ff3)
        begin
            next_s.out = s.ff3;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            // Idle level is a constant tie, not a sampled pin
            s <= {4{rst_level}};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign pin_clean = s.out;

endmodule : oes_sync

/* File: oes_fault_det.sv */
// Purpose: Falling-edge or consecutive-low detector of one fault input
// Assumes: level_n already synchronised; presc free-running shared counter
// Notes:   accept is a one-cycle pulse
`timescale 1ns/1ps
`include "oes_cfg.svh"

module oes_fault_det
#(
    parameter bit EXTENDED = 1'b1
)
(
    input  wire logic                    mclk,
    input  wire logic                    reset,
    input  wire logic                    level_n,
    input  wire logic [3:0]              mode,
    input  wire logic [3:0]              count_sel,
    input  wire logic [`OES_PRESC_W-1:0] presc,
    output logic                         accept
);

    typedef struct packed
    {
        logic                  prev;
        logic [`OES_RUN_W-1:0] run;
        logic                  acc;
    } oes_det_state_type;

    oes_det_state_type s;
    oes_det_state_type next_s;
    logic [`OES_RUN_W-1:0] target;

    always_comb
    begin
        next_s      = s;
        target      = oes_pkg::oes_target(EXTENDED, count_sel);
        next_s.prev = level_n;
        next_s.acc  = 1'b0;
        if (mode == oes_pkg::OES_EDGE)
        begin
            next_s.run = '0;
            next_s.acc = s.prev & ~level_n; // R1 R6
        end
        else if (oes_pkg::oes_tick(mode, presc)) // R2 R3 R6
        begin
            if (level_n)
            begin
                // A single high sample restarts the run
                next_s.run = '0;
            end
            else if (s.run < target)
            begin
                next_s.run = s.run + `OES_RUN_W'(1);
                next_s.acc = (s.run + `OES_RUN_W'(1)) == target; // R5 R7 R13
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s <= '{prev: 1'b1, run: '0, acc: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign accept = s.acc;

endmodule : oes_fault_det

/* File: oes_top.sv */
// Purpose: Emergency output stop unit for complementary PWM outputs
// Assumes: mclk at 100 MHz; PWM outputs active high; pin pairs 0/1 and 2/3
// Notes:   EXTENDED=1 stops pins at low level, EXTENDED=0 floats them
//
// Overview of operation
// R1: In the extended variant, mode 0000 accepts a request on a falling edge of the fault input.
// R2: Extended modes 0001, 0010, 0011 sample at clock/8, /16, /128 and accept on a low run.
// R3: Extended modes 0100, 0101, 0110 sample at clock/1, /2, /4 with the same acceptance.
// R4: Software writes only listed mode codes; other codes behave undefined.
// R5: Extended variant has a 4-bit sample count field per fault input setting the run length.
// R6: Basic variant mode 00 is edge; 01, 10, 11 sample at clock/8, /16, /128.
// R7: Basic variant level modes need sixteen consecutive low samples.
// R8: Each fault input has a flag that reads 1 once its request has been accepted.
// R9: Basic variant places the controlled pins in high impedance when stopped.
// R10: With the oscillation stop enable set, a detected oscillation stop stops all pins.
// R11: The oscillation stop flag reads 1 when a stop request came from oscillation stop.
// R12: Each complementary pair has an enable that stops pins when both sides are active.
// R13: Extended sample count choices are 4, 8 or 16 samples.
// R14: Any accepted fault request stops all controlled pins.
// R15: Input sampling and output comparison results raise interrupts.
// R16: Flags clear only by writing 0 after reading 1; the stop holds while any flag is set (osc and overlap flags hold it only while enabled).
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "oes_cfg.svh"

module oes_top
#(
    parameter bit EXTENDED = 1'b1
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic [`OES_ADDR_W-1:0] reg_addr,
    input  wire logic [`OES_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`OES_DATA_W-1:0] reg_rdata,
    input  wire logic                   fault_in_a_n,
    input  wire logic                   fault_in_b_n,
    input  wire logic                   fault_in_c_n,
    input  wire logic                   osc_stop_det,
    input  wire logic [3:0]             pwm_in,
    output logic      [3:0]             pin_out,
    output logic      [3:0]             pin_oe,
    output logic                        stop_active,
    output logic                        irq
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (EXTENDED !== 1'b1 && EXTENDED !== 1'b0)
    begin : g_bad_param
        $error("EXTENDED must be 0 or 1");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [`OES_NUM_FAULT-1:0][3:0] mode;
        logic [`OES_NUM_FAULT-1:0][3:0] cnt;
        logic [2:0]                     en;
        logic [`OES_EVT_W-1:0]          flag;
        logic [`OES_EVT_W-1:0]          armed;
        logic [`OES_EVT_W-1:0]          irq_stat;
        logic [`OES_EVT_W-1:0]          irq_mask;
        logic [`OES_PRESC_W-1:0]        presc;
        logic [`OES_DATA_W-1:0]         rdata;
        logic [3:0]                     pin_out;
        logic [3:0]                     pin_oe;
    } oes_top_state_type;

    oes_top_state_type s;
    oes_top_state_type next_s;

    logic [3:0]                raw_in;
    logic [3:0]                clean_in;
    logic [`OES_NUM_FAULT-1:0] accept;
    logic [`OES_EVT_W-1:0]     ev;
    logic                      stop;

    // ----------------------------------------------------------------
    // Input synchronisers and fault detectors
    // ----------------------------------------------------------------
    assign raw_in = {osc_stop_det, fault_in_c_n, fault_in_b_n, fault_in_a_n};

    for (genvar g = 0; g < 4; g++)
    begin : g_sync
        oes_sync u_sync
        (
            .mclk      (mclk),
            .reset     (reset),
            .pin_raw   (raw_in[g]),
            .rst_level (g < 3),
            .pin_clean (clean_in[g])
        );
    end

    for (genvar g = 0; g < `OES_NUM_FAULT; g++)
    begin : g_det
        oes_fault_det #(.EXTENDED(EXTENDED)) u_det
        (
            .mclk      (mclk),
            .reset     (reset),
            .level_n   (clean_in[g]),
            .mode      (s.mode[g]),
            .count_sel (s.cnt[g]),
            .presc     (s.presc),
            .accept    (accept[g])
        );
    end

    // ----------------------------------------------------------------
    // Stop sources
    // ----------------------------------------------------------------
    assign ev[2:0] = accept;                                 // R8 R14
    assign ev[3]   = clean_in[3] & s.en[0];                  // R10 R11
    assign ev[4]   = pwm_in[0] & pwm_in[1] & s.en[1];        // R12
    assign ev[5]   = pwm_in[2] & pwm_in[3] & s.en[2];        // R12

    // Enabled flags keep the stop; a disabled source releases it
    assign stop = (|s.flag[2:0]) | (|(s.flag[5:3] & s.en)); // R14 R16

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [`OES_ADDR_W-1:0] idx;
        logic [`OES_DATA_W-1:0] v;
        idx    = reg_addr;
        v      = '0;
        next_s = s;

        next_s.presc = `OES_PRESC_W'(s.presc + `OES_PRESC_STEP);

        // Read view
        if (idx < `OES_OFS_IRQ_STAT)
        begin
            v[`OES_FLAG_BIT] = s.flag[idx]; // R8 R11
            if (idx < `OES_OFS_OSC)
            begin
                v[`OES_MODE_MSB:`OES_MODE_LSB] = s.mode[idx];
                v[`OES_CNT_MSB:`OES_CNT_LSB]   = s.cnt[idx];
            end
            else
            begin
                v[`OES_EN_BIT] = s.en[2'(idx - `OES_OFS_OSC)];
            end
        end
        else if (idx == `OES_OFS_IRQ_STAT)
        begin
            v[`OES_EVT_W-1:0] = s.irq_stat;
        end
        else
        begin
            v[`OES_EVT_W-1:0] = s.irq_mask;
        end

        if (reg_rd)
        begin
            next_s.rdata = v;
            if (idx < `OES_OFS_IRQ_STAT && s.flag[idx])
            begin
                next_s.armed[idx] = 1'b1; // R16
            end
            if (idx == `OES_OFS_IRQ_STAT)
            begin
                next_s.irq_stat = '0;
            end
        end

        if (reg_wr)
        begin
            if (idx < `OES_OFS_IRQ_STAT)
            begin
                if (!reg_wdata[`OES_FLAG_BIT] && s.armed[idx])
                begin
                    next_s.flag[idx]  = 1'b0; // R16
                    next_s.armed[idx] = 1'b0;
                end
                if (idx < `OES_OFS_OSC)
                begin
                    // Basic variant keeps only two mode bits and no count field
                    next_s.mode[idx] = EXTENDED ? reg_wdata[`OES_MODE_MSB:`OES_MODE_LSB]
                                     : {2'b00, reg_wdata[`OES_BASIC_MODE_MSB:`OES_MODE_LSB]};
                    next_s.cnt[idx]  = EXTENDED ? reg_wdata[`OES_CNT_MSB:`OES_CNT_LSB]
                                     : 4'h0; // R5 R7
                end
                else
                begin
                    next_s.en[2'(idx - `OES_OFS_OSC)] = reg_wdata[`OES_EN_BIT]; // R10 R12
                end
            end
            else if (idx == `OES_OFS_IRQ_MASK)
            begin
                next_s.irq_mask = reg_wdata[`OES_EVT_W-1:0];
            end
        end

        // Hardware set wins over any clear in the same cycle
        next_s.irq_stat = next_s.irq_stat | (ev & ~s.flag); // R15
        next_s.flag     = next_s.flag | ev;                 // R8 R11

        // Pins: extended drives the stopped level, basic floats
        if (stop)
        begin
            next_s.pin_out = `OES_PIN_STOP_LVL;                               // R14
            next_s.pin_oe  = EXTENDED ? `OES_PIN_ALL_ON : `OES_PIN_OE_RST;   // R9
        end
        else
        begin
            next_s.pin_out = pwm_in;
            next_s.pin_oe  = `OES_PIN_ALL_ON;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata   = s.rdata;
    assign pin_out     = s.pin_out;
    assign pin_oe      = s.pin_oe;
    assign stop_active = stop;
    assign irq         = |(s.irq_stat & s.irq_mask); // R15

endmodule : oes_top

/* File: oes_sva.sv */
// Purpose: Port-level assertions of the output stop unit
// Assumes: One clock domain, reset synchronous and active high
// Notes:   Cause window allows for pin sync plus edge latency
`timescale 1ns/1ps

module oes_sva
#(
    parameter bit EXTENDED = 1'b1
)
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        fault_in_a_n,
    input wire logic        fault_in_b_n,
    input wire logic        fault_in_c_n,
    input wire logic        osc_stop_det,
    input wire logic [3:0]  pwm_in,
    input wire logic [3:0]  pin_out,
    input wire logic [3:0]  pin_oe,
    input wire logic        stop_active,
    input wire logic        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // Cycles since a stop cause was last seen
    // ----------------------------------------------------------------
    logic       cause;
    logic [3:0] cause_age;

    assign cause = ~(fault_in_a_n & fault_in_b_n & fault_in_c_n) | osc_stop_det |
                   (&pwm_in[1:0]) | (&pwm_in[3:2]);

    always_ff @(posedge mclk)
    begin
        if (reset)
            cause_age <= 4'hF;
        else if (cause)
            cause_age <= 4'h0;
        else if (cause_age != 4'hF)
            cause_age <= cause_age + 4'h1;
    end

    a_stopped_pins:
        assert property ($past(stop_active) |->
                         pin_out == 4'h0 && pin_oe == (EXTENDED ? 4'hF : 4'h0))
        else $error("pins not stopped");
    a_running_pins:
        assert property (!$past(stop_active) && !$past(reset) |->
                         pin_oe == 4'hF && pin_out == $past(pwm_in))
        else $error("pins not following pwm");
    a_reset_quiet:
        assert property ($past(reset) |-> pin_oe == 4'h0 && reg_rdata == 16'h0000 &&
                         !stop_active && !irq)
        else $error("outputs active after reset");
    a_rdata_still:
        assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");
    a_stop_cause:
        assert property ($rose(stop_active) |-> cause_age <= 4'h8 || $past(reg_wr))
        else $error("stop without cause");
    a_stop_holds:
        assert property ($fell(stop_active) |-> $past(reg_wr))
        else $error("stop released without write");
    a_irq_rise:
        assert property ($rose(irq) |-> stop_active || $past(reg_wr))
        else $error("irq without event");
    a_irq_fall:
        assert property ($fell(irq) |-> $past(reg_rd) || $past(reg_wr))
        else $error("irq dropped without access");
endmodule : oes_sva

bind oes_top oes_sva #(.EXTENDED(EXTENDED)) i_oes_sva (.mclk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fault_in_a_n, .fault_in_b_n, .fault_in_c_n, .osc_stop_det,
    .pwm_in, .pin_out, .pin_oe, .stop_active, .irq);

/* File: oes_far.sv */
// Purpose: Fault sources and complementary timer outputs facing the unit
// Assumes: Commands from the bench change just after a rising edge
// Notes:   Fault lines are pulled up while no fault is commanded
`timescale 1ns/1ps

module oes_far
(
    input  wire logic       mclk,
    input  wire logic [2:0] fault_cmd,
    input  wire logic       osc_cmd,
    input  wire logic [1:0] overlap_cmd,
    output logic            fault_in_a_n,
    output logic            fault_in_b_n,
    output logic            fault_in_c_n,
    output logic            osc_stop_det,
    output logic [3:0]      pwm_in
);
    logic [3:0] phase;

    initial
    begin
        phase = 4'h0;
        {fault_in_c_n, fault_in_b_n, fault_in_a_n} = 3'h7;
        osc_stop_det = 1'b0;
        pwm_in = 4'h6;
    end

    // Pairs stay complementary unless an overlap is commanded
    always @(posedge mclk)
    begin
        phase <= phase + 4'h1;
        {fault_in_c_n, fault_in_b_n, fault_in_a_n} <= ~fault_cmd;
        osc_stop_det <= osc_cmd;
        pwm_in[1:0] <= overlap_cmd[0] ? 2'h3 : {~phase[2], phase[2]};
        pwm_in[3:2] <= overlap_cmd[1] ? 2'h3 : {~phase[3], phase[3]};
    end
endmodule : oes_far

/* File: tb.sv */
// Purpose: Self-checking bench of the output stop unit
// Assumes: Extended variant, mask register at index 7
// Notes:   Stop delays checked against windows, not exact cycles
`timescale 1ns/1ps

module tb;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        fault_in_a_n, fault_in_b_n, fault_in_c_n, osc_stop_det;
    logic        stop_active, irq;
    logic [3:0]  pwm_in, pin_out, pin_oe;
    logic [2:0]  fault_cmd = 3'h0;
    logic        osc_cmd = 1'b0;
    logic [1:0]  overlap_cmd = 2'h0;
    logic [15:0] rv, cfg;
    int          f, c;
    int          n_fail = 0;
    int          checks_done = 0;

    always #5 mclk = ~mclk;

    oes_top #(.EXTENDED(1'b1)) i_oes_top (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fault_in_a_n, .fault_in_b_n, .fault_in_c_n, .osc_stop_det,
        .pwm_in, .pin_out, .pin_oe, .stop_active, .irq);
    oes_far i_oes_far (.mclk, .fault_cmd, .osc_cmd, .overlap_cmd, .fault_in_a_n,
        .fault_in_b_n, .fault_in_c_n, .osc_stop_det, .pwm_in);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int div_of(input int m);
        return m == 3 ? 128 : m < 3 ? 4 << m : 1 << (m - 4);
    endfunction : div_of

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Strobe drops at the taking edge; one idle edge before the next
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask : rd

    task automatic st(input logic [1:0] e);
        @(negedge mclk);
        chk({14'h0, stop_active, irq}, {14'h0, e}, "stop and irq");
        if (e[1])
            chk({8'h00, pin_oe, pin_out}, 16'h00F0, "stopped pins");
        else
            chk({12'h000, pin_oe}, 16'h000F, "running pin enable");
        @(posedge mclk);
    endtask : st

    task automatic wait_stop(input int lo, input int hi);
        int n;
        n = 0;
        @(negedge mclk);
        while (stop_active !== 1'b1 && n < hi)
        begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n >= lo && n <= hi && stop_active === 1'b1), 16'h1, "stop delay");
        @(posedge mclk);
    endtask : wait_stop

    task automatic wrap_up;
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h23A0B966));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), rv);
            chk(rv, 16'h0000, "reset value");
        end
        wr(3'h7, 16'h003F);
        for (int m = 0; m < 7; m++)
        begin
            f = $urandom_range(2);
            c = $urandom_range(2);
            cfg = {8'h00, 4'(c), 4'(m)};
            wr(3'(f), cfg);
            fault_cmd[f] <= 1'b1;
            if (m == 0)
                wait_stop(2, 9);
            else
                wait_stop(div_of(m) * ((4 << c) - 1) + 2, div_of(m) * (4 << c) + 8);
            st(2'b11);
            rd(3'(f), rv);
            chk(rv, cfg | 16'h8000, "fault flag");
            rd(3'h6, rv);
            chk(rv, 16'(1 << f), "irq status");
            fault_cmd[f] <= 1'b0;
            repeat (6) @(posedge mclk);
            st(2'b10);
            wr(3'(f), cfg);
            st(2'b00);
        end
        // Low run shorter than the count must be ignored
        wr(3'h0, 16'h0004);
        fault_cmd[0] <= 1'b1;
        repeat (2) @(posedge mclk);
        fault_cmd[0] <= 1'b0;
        repeat (10) @(posedge mclk);
        st(2'b00);
        rd(3'h0, rv);
        chk(rv, 16'h0004, "short low run");
        wr(3'h7, 16'h0037);
        osc_cmd <= 1'b1;
        repeat (12) @(posedge mclk);
        st(2'b00);
        wr(3'h3, 16'h0200);
        wait_stop(0, 6);
        osc_cmd <= 1'b0;
        st(2'b10);
        wr(3'h7, 16'h003F);
        repeat (6) @(posedge mclk);
        st(2'b11);
        rd(3'h3, rv);
        chk(rv, 16'h8200, "osc flag");
        rd(3'h6, rv);
        chk(rv, 16'h0008, "irq status");
        wr(3'h3, 16'h0000);
        st(2'b00);
        for (int g = 0; g < 2; g++)
        begin
            overlap_cmd[g] <= 1'b1;
            repeat (4) @(posedge mclk);
            st(2'b00);
            overlap_cmd[g] <= 1'b0;
            wr(3'(4 + g), 16'h0200);
            overlap_cmd[g] <= 1'b1;
            wait_stop(0, 4);
            overlap_cmd[g] <= 1'b0;
            rd(3'(4 + g), rv);
            chk(rv, 16'h8200, "overlap flag");
            rd(3'h6, rv);
            chk(rv, 16'(1 << (4 + g)), "irq status");
            wr(3'(4 + g), 16'h0000);
            st(2'b00);
        end
        wrap_up();
    end
endmodule : tb
